/* verilog/shlc_consts.svh */
// Constants for the serial host link configuration block
// Behaviour
// - Character-length switch on gives eight data bits, off gives seven.
// - Stop-bit switch on gives one stop bit, off gives two.
// - Parity switches: on/on none, off/on even, off/off odd.
// - Flow switches: on/off none, off/on request/clear, off/off XON/XOFF
// - Baud switches pick 19200, 9600, 4800, 2400, 1200, 600 or 300 bps.
// - Only the eight listed framings are valid; others are flagged.
// - Both ends should run the highest rate both support.
// - Device receives on transmit and request lines, drives the others.
// - Error-release switch off clears errors on its own; on holds them.
// - Host-run switch on ignores host run control; off accepts it.
// - Mode-change switch on permits mode changes; off blocks them.
// - Reserved option switch must read on; off is flagged.
// - Communication-specification switch must read off with this link.
// - The link joins exactly one terminal to one host, no addressing.
`ifndef SHLC_CONSTS_SVH
`define SHLC_CONSTS_SVH
`define SHLC_CLK_HZ 25000000
`define SHLC_XON 8'h11
`define SHLC_XOFF 8'h13
`define SHLC_DIV_19200 16'd1302
`define SHLC_DIV_9600 16'd2604
`define SHLC_DIV_4800 16'd5208
`define SHLC_DIV_2400 16'd10416
`define SHLC_DIV_1200 16'd20833
`define SHLC_DIV_600 16'd41666
`define SHLC_DIV_300 17'd83333
`define SHLC_ERR_HOLD_US 1000
`define SHLC_ERR_HOLD_CYC (`SHLC_ERR_HOLD_US * (`SHLC_CLK_HZ / 1000000))
`endif

/* verilog/shlc_pkg.sv */
// Types for the serial host link configuration block
package shlc_pkg;
    typedef enum logic [1:0] {
        SHLC_PAR_NONE = 2'h0,
        SHLC_PAR_EVEN = 2'h1,
        SHLC_PAR_ODD = 2'h3
    } shlc_par_t;
    typedef enum logic [1:0] {
        SHLC_FLOW_NONE = 2'h0,
        SHLC_FLOW_HW = 2'h1,
        SHLC_FLOW_SW = 2'h3
    } shlc_flow_t;
    typedef enum logic [2:0] {
        SHLC_S_IDLE = 3'h0,
        SHLC_S_START = 3'h1,
        SHLC_S_DATA = 3'h3,
        SHLC_S_PAR = 3'h2,
        SHLC_S_STOP = 3'h6
    } shlc_state_t;
endpackage : shlc_pkg

/* verilog/shlc_baud_gen.sv */
// Baud tick generator: one tick per bit time, half tick for mid-bit sampling
`include "shlc_consts.svh"
module shlc_baud_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic [2:0] baud_sel,
    input wire logic restart,
    // Ticks
    output logic tick,
    output logic half
);
    logic [16:0] div;
    logic [16:0] cnt_q;
    always_comb begin
        case (baud_sel)
            3'h6: div = 17'(`SHLC_DIV_19200);
            3'h5: div = 17'(`SHLC_DIV_9600);
            3'h4: div = 17'(`SHLC_DIV_4800);
            3'h3: div = 17'(`SHLC_DIV_2400);
            3'h2: div = 17'(`SHLC_DIV_1200);
            3'h1: div = 17'(`SHLC_DIV_600);
            default: div = `SHLC_DIV_300;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 17'h0;
        end else if (restart || cnt_q >= div - 17'h1) begin
            cnt_q <= 17'h0;
        end else begin
            cnt_q <= cnt_q + 17'h1;
        end
    end
    assign tick = !restart && (cnt_q == div - 17'h1);
    assign half = !restart && (cnt_q == {1'b0, div[16:1]});
endmodule : shlc_baud_gen

/* verilog/shlc_link.sv */
// Serial host link: switch decode, transmitter, receiver, flow control
`include "shlc_consts.svh"
module shlc_link (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Link format switch bank, 1 = on
    input wire logic [9:0] LINK_FORMAT_SWITCH_BANK,
    // Terminal option switch bank, 1 = on
    input wire logic [7:0] TERMINAL_OPTION_SWITCH_BANK,
    // Serial lines, device side
    input wire logic TRANSMIT_LINE,
    input wire logic REQUEST_LINE,
    output logic RECEIVE_LINE,
    output logic CLEAR_LINE,
    // Transmit user side
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    output logic TX_READY,
    // Receive user side
    output logic RX_VALID,
    output logic [7:0] RX_DATA,
    input wire logic RX_READY,
    // Host run and mode change requests
    input wire logic HOST_RUN_REQ,
    input wire logic MODE_CHANGE_REQ,
    output logic HOST_RUN_ACCEPT,
    output logic MODE_CHANGE_ACCEPT,
    // Status
    input wire logic ERR_CLEAR,
    output logic LINK_ERROR,
    output logic CONFIG_INVALID
);
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Switch decode
    logic eight, one_stop;
    shlc_pkg::shlc_par_t par;
    shlc_pkg::shlc_flow_t flow;
    logic par_bad, flow_bad, baud_bad, frame_bad;
    logic [2:0] baud_sel;
    assign eight = LINK_FORMAT_SWITCH_BANK[0];
    assign one_stop = LINK_FORMAT_SWITCH_BANK[1];
    always_comb begin
        par_bad = 1'b0;
        case (LINK_FORMAT_SWITCH_BANK[3:2])
            2'h3: par = shlc_pkg::SHLC_PAR_NONE;
            2'h2: par = shlc_pkg::SHLC_PAR_EVEN;
            2'h0: par = shlc_pkg::SHLC_PAR_ODD;
            default: begin
                par = shlc_pkg::SHLC_PAR_NONE;
                par_bad = 1'b1;
            end
        endcase
        flow_bad = 1'b0;
        case (LINK_FORMAT_SWITCH_BANK[5:4])
            2'h1: flow = shlc_pkg::SHLC_FLOW_NONE;
            2'h2: flow = shlc_pkg::SHLC_FLOW_HW;
            2'h0: flow = shlc_pkg::SHLC_FLOW_SW;
            default: begin
                flow = shlc_pkg::SHLC_FLOW_NONE;
                flow_bad = 1'b1;
            end
        endcase
    end
    // Bit order 7,8,9 on switches; on/on/on has no rate and falls to 300
    assign baud_sel = {LINK_FORMAT_SWITCH_BANK[6], LINK_FORMAT_SWITCH_BANK[7],
                       LINK_FORMAT_SWITCH_BANK[8]};
    assign baud_bad = (baud_sel == 3'h7);
    // 7 data bits need parity; 8 data bits with parity need one stop
    assign frame_bad = (!eight && par == shlc_pkg::SHLC_PAR_NONE) ||
                       (eight && par != shlc_pkg::SHLC_PAR_NONE &&
                        !one_stop);
    assign CONFIG_INVALID = frame_bad || par_bad || flow_bad || baud_bad ||
                            !TERMINAL_OPTION_SWITCH_BANK[2] ||
                            TERMINAL_OPTION_SWITCH_BANK[7];

    // Run and mode gating
    assign HOST_RUN_ACCEPT = HOST_RUN_REQ &&
                             !TERMINAL_OPTION_SWITCH_BANK[1];
    assign MODE_CHANGE_ACCEPT = MODE_CHANGE_REQ &&
                                TERMINAL_OPTION_SWITCH_BANK[5];

    // Baud generators, one per direction so each aligns to its own frame
    logic tx_tick, rx_tick, rx_half, tx_restart, rx_restart;
    shlc_baud_gen u_tx_baud (
        .clk(SYS_CLK),
        .rst_n(rst_n_q),
        .baud_sel(baud_sel),
        .restart(tx_restart),
        .tick(tx_tick),
        .half()
    );
    shlc_baud_gen u_rx_baud (
        .clk(SYS_CLK),
        .rst_n(rst_n_q),
        .baud_sel(baud_sel),
        .restart(rx_restart),
        .tick(rx_tick),
        .half(rx_half)
    );

    // Flow control state toward this device's transmitter
    logic paused_q, xoff_seen, xon_seen;
    logic tx_go;
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            paused_q <= 1'b0;
        end else if (flow != shlc_pkg::SHLC_FLOW_SW) begin
            paused_q <= 1'b0;
        end else if (xoff_seen) begin
            paused_q <= 1'b1;
        end else if (xon_seen) begin
            paused_q <= 1'b0;
        end
    end
    // Host request line is its ready-to-take signal in handshake mode
    assign tx_go = (flow == shlc_pkg::SHLC_FLOW_HW) ? REQUEST_LINE :
                   !paused_q;

    // Transmitter
    shlc_pkg::shlc_state_t tx_st_q;
    logic [7:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic tx_par_q, tx_line_q;
    assign TX_READY = rst_n_q && (tx_st_q == shlc_pkg::SHLC_S_IDLE) && tx_go;
    assign tx_restart = (tx_st_q == shlc_pkg::SHLC_S_IDLE);
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_st_q <= shlc_pkg::SHLC_S_IDLE;
            tx_sh_q <= 8'h0;
            tx_cnt_q <= 4'h0;
            tx_par_q <= 1'b0;
            tx_line_q <= 1'b1;
        end else begin
            case (tx_st_q)
                shlc_pkg::SHLC_S_IDLE: begin
                    tx_line_q <= 1'b1;
                    if (TX_VALID && TX_READY) begin
                        tx_sh_q <= eight ? TX_DATA : {1'b0, TX_DATA[6:0]};
                        tx_par_q <= par == shlc_pkg::SHLC_PAR_ODD;
                        tx_line_q <= 1'b0;
                        tx_st_q <= shlc_pkg::SHLC_S_START;
                    end
                end
                shlc_pkg::SHLC_S_START: if (tx_tick) begin
                    tx_line_q <= tx_sh_q[0];
                    tx_par_q <= tx_par_q ^ tx_sh_q[0];
                    tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                    tx_cnt_q <= eight ? 4'h7 : 4'h6;
                    tx_st_q <= shlc_pkg::SHLC_S_DATA;
                end
                shlc_pkg::SHLC_S_DATA: if (tx_tick) begin
                    if (tx_cnt_q != 4'h0) begin
                        tx_line_q <= tx_sh_q[0];
                        tx_par_q <= tx_par_q ^ tx_sh_q[0];
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                        tx_cnt_q <= tx_cnt_q - 4'h1;
                    end else if (par != shlc_pkg::SHLC_PAR_NONE) begin
                        tx_line_q <= tx_par_q;
                        tx_st_q <= shlc_pkg::SHLC_S_PAR;
                    end else begin
                        tx_line_q <= 1'b1;
                        tx_cnt_q <= one_stop ? 4'h0 : 4'h1;
                        tx_st_q <= shlc_pkg::SHLC_S_STOP;
                    end
                end
                shlc_pkg::SHLC_S_PAR: if (tx_tick) begin
                    tx_line_q <= 1'b1;
                    tx_cnt_q <= one_stop ? 4'h0 : 4'h1;
                    tx_st_q <= shlc_pkg::SHLC_S_STOP;
                end
                shlc_pkg::SHLC_S_STOP: if (tx_tick) begin
                    if (tx_cnt_q != 4'h0) begin
                        tx_cnt_q <= tx_cnt_q - 4'h1;
                    end else begin
                        tx_st_q <= shlc_pkg::SHLC_S_IDLE;
                    end
                end
                default: tx_st_q <= shlc_pkg::SHLC_S_IDLE;
            endcase
        end
    end
    assign RECEIVE_LINE = tx_line_q;

    // Receiver; the input is treated as synchronous to SYS_CLK
    shlc_pkg::shlc_state_t rx_st_q;
    logic [7:0] rx_sh_q;
    logic [3:0] rx_cnt_q;
    logic rx_par_q, rx_valid_q, rx_err_ev, rx_done;
    logic [7:0] rx_data_q;
    logic [7:0] rx_char;
    assign rx_restart = (rx_st_q == shlc_pkg::SHLC_S_IDLE);
    assign rx_char = eight ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_st_q <= shlc_pkg::SHLC_S_IDLE;
            rx_sh_q <= 8'h0;
            rx_cnt_q <= 4'h0;
            rx_par_q <= 1'b0;
        end else begin
            case (rx_st_q)
                shlc_pkg::SHLC_S_IDLE: if (!TRANSMIT_LINE) begin
                    rx_st_q <= shlc_pkg::SHLC_S_START;
                end
                shlc_pkg::SHLC_S_START: if (rx_half) begin
                    // Glitch shorter than half a bit is not a start
                    if (TRANSMIT_LINE) begin
                        rx_st_q <= shlc_pkg::SHLC_S_IDLE;
                    end else begin
                        rx_cnt_q <= eight ? 4'h8 : 4'h7;
                        rx_par_q <= par == shlc_pkg::SHLC_PAR_ODD;
                        rx_st_q <= shlc_pkg::SHLC_S_DATA;
                    end
                end
                shlc_pkg::SHLC_S_DATA: if (rx_half) begin
                    if (rx_cnt_q != 4'h0) begin
                        rx_sh_q <= {TRANSMIT_LINE, rx_sh_q[7:1]};
                        rx_par_q <= rx_par_q ^ TRANSMIT_LINE;
                        rx_cnt_q <= rx_cnt_q - 4'h1;
                    end else if (par != shlc_pkg::SHLC_PAR_NONE) begin
                        rx_par_q <= rx_par_q ^ TRANSMIT_LINE;
                        rx_st_q <= shlc_pkg::SHLC_S_PAR;
                    end else begin
                        rx_st_q <= shlc_pkg::SHLC_S_IDLE;
                    end
                end
                shlc_pkg::SHLC_S_PAR: rx_st_q <= shlc_pkg::SHLC_S_STOP;
                // Only the first stop is checked so the next start is not missed
                shlc_pkg::SHLC_S_STOP: if (rx_half) begin
                    rx_st_q <= shlc_pkg::SHLC_S_IDLE;
                end
                default: rx_st_q <= shlc_pkg::SHLC_S_IDLE;
            endcase
        end
    end
    // Without parity the first stop is sampled while still in the data state
    assign rx_done = rx_half && ((rx_st_q == shlc_pkg::SHLC_S_STOP) ||
                     (rx_st_q == shlc_pkg::SHLC_S_DATA && rx_cnt_q == 4'h0 &&
                      par == shlc_pkg::SHLC_PAR_NONE));
    assign rx_err_ev = rx_done && (!TRANSMIT_LINE ||
                       (par != shlc_pkg::SHLC_PAR_NONE && rx_par_q) ||
                       (rx_valid_q && !RX_READY));
    assign xoff_seen = rx_done && !rx_err_ev && rx_char == `SHLC_XOFF;
    assign xon_seen = rx_done && !rx_err_ev && rx_char == `SHLC_XON;

    // Flow codes are consumed, not handed to the user
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_valid_q <= 1'b0;
            rx_data_q <= 8'h0;
        end else if (rx_done && !rx_err_ev && !(xoff_seen || xon_seen)
                     ) begin
            rx_valid_q <= 1'b1;
            rx_data_q <= rx_char;
        end else if (RX_READY) begin
            rx_valid_q <= 1'b0;
        end
    end
    assign RX_VALID = rx_valid_q;
    assign RX_DATA = rx_data_q;
    // Hold off the host while a character waits unread
    assign CLEAR_LINE = (flow == shlc_pkg::SHLC_FLOW_HW) ? !rx_valid_q :
                        1'b1;

    // Error state with optional automatic release
    logic err_q;
    logic [15:0] err_cnt_q;
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            err_q <= 1'b0;
            err_cnt_q <= 16'h0;
        end else if (rx_err_ev) begin
            err_q <= 1'b1; // Set wins over clear
            err_cnt_q <= 16'h0;
        end else if (err_q) begin
            if (ERR_CLEAR) begin
                err_q <= 1'b0;
            end else if (!TERMINAL_OPTION_SWITCH_BANK[0]) begin
                if (err_cnt_q == 16'(`SHLC_ERR_HOLD_CYC - 1)) begin
                    err_q <= 1'b0;
                end else begin
                    err_cnt_q <= err_cnt_q + 16'h1;
                end
            end
        end
    end
    assign LINK_ERROR = err_q;
endmodule : shlc_link

/* dv/shlc_link_props.sv */
// Assertion checker for the serial host link ports
module shlc_link_props (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Switch banks
    input wire logic [9:0] LINK_FORMAT_SWITCH_BANK,
    input wire logic [7:0] TERMINAL_OPTION_SWITCH_BANK,
    // Lines and handshakes
    input wire logic REQUEST_LINE,
    input wire logic RECEIVE_LINE,
    input wire logic CLEAR_LINE,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_READY,
    // Requests and status
    input wire logic HOST_RUN_REQ,
    input wire logic MODE_CHANGE_REQ,
    input wire logic HOST_RUN_ACCEPT,
    input wire logic MODE_CHANGE_ACCEPT,
    input wire logic ERR_CLEAR,
    input wire logic LINK_ERROR,
    input wire logic CONFIG_INVALID
);
    wire [9:0] fs = LINK_FORMAT_SWITCH_BANK;
    wire [7:0] os = TERMINAL_OPTION_SWITCH_BANK;
    wire hw = fs[5:4] == 2'h2;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);
    chk_run_gate: assert property (
        HOST_RUN_ACCEPT == (HOST_RUN_REQ && !os[1])) else $error("Run gate");
    chk_mode_gate: assert property (
        MODE_CHANGE_ACCEPT == (MODE_CHANGE_REQ && os[5])) else $error("Mode");
    chk_frame_flag: assert property (
        (!fs[0] && fs[3:2] == 2'h3) || (fs[0] && !fs[1] && !fs[2])
        |-> CONFIG_INVALID) else $error("Bad framing not flagged");
    chk_reserved_flag: assert property (
        !os[2] |-> CONFIG_INVALID) else $error("Reserved switch not flagged");
    chk_spec_flag: assert property (
        os[7] |-> CONFIG_INVALID) else $error("Spec switch not flagged");
    chk_start_bit: assert property (
        TX_VALID && TX_READY |=> !RECEIVE_LINE) else $error("No start bit");
    chk_tx_busy: assert property (
        TX_VALID && TX_READY |=> !TX_READY [*8]) else $error("Ready too soon");
    chk_flow_idle: assert property (
        !hw |-> CLEAR_LINE) else $error("Clear line low without handshake");
    chk_flow_stop: assert property (
        (hw && !REQUEST_LINE) [*3] |-> !TX_READY) else $error("Sent on stop");
    chk_rx_hold: assert property (
        RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
        else $error("Received word lost");
    chk_err_hold: assert property (
        os[0] && LINK_ERROR && !ERR_CLEAR && !$past(ERR_CLEAR) |=> LINK_ERROR)
        else $error("Error released on its own");
    cover property (TX_VALID && TX_READY);
    cover property ($rose(RX_VALID));
    cover property ($rose(LINK_ERROR));
endmodule : shlc_link_props

bind shlc_link shlc_link_props i_shlc_link_props (.SYS_CLK(SYS_CLK),
    .RSTN(RSTN), .LINK_FORMAT_SWITCH_BANK(LINK_FORMAT_SWITCH_BANK),
    .TERMINAL_OPTION_SWITCH_BANK(TERMINAL_OPTION_SWITCH_BANK),
    .REQUEST_LINE(REQUEST_LINE), .RECEIVE_LINE(RECEIVE_LINE),
    .CLEAR_LINE(CLEAR_LINE), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_READY(RX_READY),
    .HOST_RUN_REQ(HOST_RUN_REQ), .MODE_CHANGE_REQ(MODE_CHANGE_REQ),
    .HOST_RUN_ACCEPT(HOST_RUN_ACCEPT), .MODE_CHANGE_ACCEPT(MODE_CHANGE_ACCEPT),
    .ERR_CLEAR(ERR_CLEAR), .LINK_ERROR(LINK_ERROR),
    .CONFIG_INVALID(CONFIG_INVALID));

/* dv/shlc_host.sv */
// Host serial port model facing the link block
module shlc_host (
    // Clock
    input wire logic clk,
    // Serial lines, host side
    input wire logic rx_line,
    output logic tx_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Mark level between characters
    initial tx_line = 1'h1;
    // par: 0 none, 1 even, 2 odd, 3 even inverted to force an error
    task automatic send(input logic [7:0] d, input int nd, input int par,
            input int ns, input int div);
        logic [11:0] f;
        int n;
        f = '1;
        f[0] = 1'h0;
        for (int i = 0; i < nd; i++) f[i+1] = d[i];
        n = nd + 1;
        if (par != 0) begin
            f[n] = ^((nd == 8) ? d : {1'h0, d[6:0]}) ^ (par > 1);
            n++;
        end
        for (int i = 0; i < n + ns; i++) begin
            tx_line = f[i];
            repeat (div) @(negedge clk);
        end
    endtask : send
    // Samples each bit mid-way; bit 0 of the result is the start bit
    task automatic grab(input int n, input int div, output logic [11:0] f);
        int k;
        f = '1;
        k = 0;
        while (rx_line && k < 5000) begin
            @(negedge clk);
            k++;
        end
        repeat (div / 2) @(negedge clk);
        for (int i = 0; i < n; i++) begin
            f[i] = rx_line;
            repeat (div) @(negedge clk);
        end
    endtask : grab
endmodule : shlc_host

/* dv/shlc_link_tb.sv */
// Self-checking bench for the serial host link
module shlc_link_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rstn, transmit_line, request_line, receive_line, clear_line;
    logic [9:0] fmt;
    logic [7:0] opt, tx_data, rx_data;
    logic tx_valid, tx_ready, rx_valid, rx_ready, err_clr, link_err, cfg_inv;
    logic run_req, mode_req, run_acc, mode_acc;
    logic [11:0] frame;
    int n_mismatch, n_compared, k, w;
    // Format switches, option switches, expected run, mode, invalid
    localparam logic [20:0] ROWS [13] = '{
        {10'h0df, 8'h04, 3'h4}, {10'h0d2, 8'h24, 3'h6}, {10'h0da, 8'h06, 3'h0},
        {10'h0de, 8'h04, 3'h5}, {10'h0d9, 8'h04, 3'h5}, {10'h0db, 8'h26, 3'h2},
        {10'h0dd, 8'h04, 3'h4}, {10'h0d0, 8'h04, 3'h4}, {10'h0df, 8'h00, 3'h5},
        {10'h0df, 8'h84, 3'h5}, {10'h0d7, 8'h04, 3'h5}, {10'h0ff, 8'h04, 3'h5},
        {10'h1df, 8'h04, 3'h5}};
    localparam int BAUDS [3] = '{19200, 9600, 4800};
    localparam logic [2:0] BSW [3] = '{3'h3, 3'h5, 3'h1};
    shlc_link i_shlc_link (.SYS_CLK(sys_clk), .RSTN(rstn),
        .LINK_FORMAT_SWITCH_BANK(fmt), .TERMINAL_OPTION_SWITCH_BANK(opt),
        .TRANSMIT_LINE(transmit_line), .REQUEST_LINE(request_line),
        .RECEIVE_LINE(receive_line), .CLEAR_LINE(clear_line),
        .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready),
        .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_READY(rx_ready),
        .HOST_RUN_REQ(run_req), .MODE_CHANGE_REQ(mode_req),
        .HOST_RUN_ACCEPT(run_acc), .MODE_CHANGE_ACCEPT(mode_acc),
        .ERR_CLEAR(err_clr), .LINK_ERROR(link_err), .CONFIG_INVALID(cfg_inv));
    shlc_host i_shlc_host (.clk(sys_clk), .rx_line(receive_line),
        .tx_line(transmit_line));
    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task print_verdict;
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task bail;
        n_mismatch++;
        print_verdict();
    endtask : bail
    task do_reset;
        rstn = 1'h0;
        tick(2);
        check({receive_line, rx_valid, link_err, tx_ready}, 4'h8);
        tick(1);
        rstn = 1'h1;
        tick(4);
    endtask : do_reset
    // Waits for a take; the valid is dropped one edge after it
    task tx_put(input logic [7:0] d);
        tx_data = d;
        tx_valid = 1'h1;
        k = 0;
        while (!tx_ready && k < 100) begin
            tick(1);
            k++;
        end
        tick(1);
        tx_valid = 1'h0;
        if (k == 100) bail();
    endtask : tx_put
    task automatic measure(output int len);
        int j;
        j = 0;
        len = 0;
        while (receive_line && j < 100) begin
            tick(1);
            j++;
        end
        while (!receive_line && len < 20000) begin
            tick(1);
            len++;
        end
        if (j == 100 || len == 20000) bail();
    endtask : measure
    task send_bad;
        i_shlc_host.send(8'h35, 7, 3, 1, 1302);
        tick(40);
        check({link_err, rx_valid}, 2'h2);
    endtask : send_bad
    initial begin
        {rstn, tx_valid, rx_ready, run_req, mode_req, err_clr} = '0;
        request_line = 1'h1;
        tx_data = 8'h00;
        fmt = 10'h0df;
        opt = 8'h04;
        n_mismatch = 0;
        n_compared = 0;
        do_reset();
        $display("Test reset done");
        {run_req, mode_req} = 2'h3;
        for (int i = 0; i < 13; i++) begin
            {fmt, opt} = ROWS[i][20:3];
            tick(2);
            check(run_acc, ROWS[i][2]);
            check(mode_acc, ROWS[i][1]);
            check(cfg_inv, ROWS[i][0]);
        end
        {run_req, mode_req, opt} = {2'h0, 8'h04};
        $display("Test switch table done");
        fmt = 10'h0ef;
        request_line = 1'h0;
        tick(4);
        check({tx_ready, clear_line}, 2'h1);
        request_line = 1'h1;
        tick(4);
        check(tx_ready, 1'h1);
        $display("Test handshake done");
        // Each rate is cut short by reset once its start bit is timed
        for (int i = 0; i < 3; i++) begin
            fmt = {1'h0, BSW[i], 6'h1f};
            do_reset();
            fork
                tx_put(8'hff);
                measure(w);
            join
            check(w[15:0], 16'(25000000 / BAUDS[i]));
        end
        do_reset();
        $display("Test baud rates done");
        fmt = 10'h0d2;
        fork
            tx_put(8'hc5);
            i_shlc_host.grab(10, 1302, frame);
        join
        check(frame[7:0], {7'h45, 1'h0});
        check(frame[9:8], {1'h1, ~^7'h45});
        $display("Test transmit frame done");
        fmt = 10'h0ef;
        i_shlc_host.send(8'ha6, 8, 0, 1, 1302);
        check({rx_valid, rx_data}, 9'h1a6);
        check(clear_line, 1'h0);
        rx_ready = 1'h1;
        tick(1);
        rx_ready = 1'h0;
        $display("Test receive frame done");
        fmt = 10'h0cf;
        i_shlc_host.send(8'h13, 8, 0, 1, 1302);
        tick(2);
        check({tx_ready, rx_valid}, 2'h0);
        fmt = 10'h0df;
        tick(2);
        check(tx_ready, 1'h1);
        $display("Test flow codes done");
        {fmt, opt} = {10'h0da, 8'h05};
        send_bad();
        err_clr = 1'h1;
        tick(1);
        err_clr = 1'h0;
        tick(2);
        check(link_err, 1'h0);
        opt = 8'h04;
        send_bad();
        k = 0;
        while (link_err && k < 27000) begin
            tick(1);
            k++;
        end
        check({k > 20000, k < 27000}, 2'h3);
        $display("Test link errors done");
        print_verdict();
    end
endmodule : shlc_link_tb
